// ---- rtl/wit_consts.svh ----
// Constants of the watchdog and interval timer
`ifndef WIT_CONSTS_SVH
`define WIT_CONSTS_SVH
// Register addresses
`define WIT_ADDR_CSR 16'hFF74
`define WIT_ADDR_CNT_RD 16'hFF75
`define WIT_ADDR_RST_WR 16'hFF76
`define WIT_ADDR_RST_RD 16'hFF77
// Upper-byte write keys
`define WIT_KEY_CNT 8'h5A
`define WIT_KEY_CSR 8'hA5
`define WIT_KEY_WCLR 8'hA5
`define WIT_KEY_RESET_ENABLE_BIT 8'h5A
// Timer control/status fields
`define WIT_CSR_OVF 7
`define WIT_CSR_MODE 6
`define WIT_CSR_TME 5
`define WIT_CSR_PSS 4
`define WIT_CSR_RTS 3
`define WIT_CSR_CKS_HI 2
`define WIT_CSR_INIT 8'h00
// Reset control/status fields
`define WIT_RST_WATCHDOG_OVERFLOW_FLAG 7
`define WIT_RST_RESET_ENABLE_BIT 6
`define WIT_RST_RSV 5
`define WIT_RST_ONES 5'h1F
// Counter values
`define WIT_CNT_ZERO 8'h00
`define WIT_CNT_TOP 8'hFF
`define WIT_RD_NONE 8'h00
// Prescaler mask base
`define WIT_PRE_ONE 16'h0001
`define WIT_PRE_TWO 16'h0002
// Cycle counts
`define WIT_RST0_CYC 10'h206
`define WIT_RST1_CYC 10'h204
`define WIT_NMI_CYC 10'h204
`define WIT_LOCK_CYC 8'h84
`endif

// ---- rtl/wit_pkg.sv ----
// Types of the watchdog and interval timer
package wit_pkg;
  // Processor register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic word;
    logic rd;
  } wit_bus_req_s;

  // Internal pulse being driven after a watchdog overflow
  typedef enum logic [1:0] {
    WIT_IDLE,
    WIT_RST,
    WIT_NMI
  } wit_pulse_e;
endpackage

// ---- rtl/wit_timer.sv ----
// Watchdog and interval timer with keyed word writes
`timescale 1ns/100ps
`include "wit_consts.svh"

module wit_timer
  import wit_pkg::*;
(
  // Clock and pin reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // Register bus
  input wire wit_bus_req_s i_bus,
  output logic [7:0] o_bus_rdata,
  // Sub-clock count source
  input wire logic i_sub_clk,
  // Chip reset and interrupt requests
  output logic o_chip_rst,
  output logic o_wdog_nmi,
  output logic o_interval_irq
);

  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] csr_r, csr_nxt;
  logic watchdog_overflow_flag_r, watchdog_overflow_flag_nxt;
  logic reset_enable_bit_r, reset_enable_bit_nxt;
  logic rsv_r, rsv_nxt;
  logic [7:0] pre_r, pre_nxt;
  logic sub_s1_r, sub_s2_r, sub_s3_r;
  logic ovf_arm_r, ovf_arm_nxt;
  logic watchdog_overflow_flag_arm_r, watchdog_overflow_flag_arm_nxt;
  logic [7:0] lock_r, lock_nxt;
  logic [9:0] pulse_r, pulse_nxt;
  wit_pulse_e pst_r, pst_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rst_o_r, rst_o_nxt;
  logic nmi_o_r, nmi_o_nxt;
  logic irq_r, irq_nxt;
  logic sub_edge, adv, tick, ovf, wd_ovf, it_ovf;
  logic wr_ok, wr_csr, wr_rst;
  logic [7:0] mask, hi, lo;

  always_comb begin
    cnt_nxt = cnt_r;
    csr_nxt = csr_r;
    watchdog_overflow_flag_nxt = watchdog_overflow_flag_r;
    reset_enable_bit_nxt = reset_enable_bit_r;
    rsv_nxt = rsv_r;
    pre_nxt = pre_r;
    ovf_arm_nxt = ovf_arm_r;
    watchdog_overflow_flag_arm_nxt = watchdog_overflow_flag_arm_r;
    lock_nxt = lock_r;
    pulse_nxt = pulse_r;
    pst_nxt = pst_r;
    rdata_nxt = rdata_r;
    hi = i_bus.wdata[15:8];
    lo = i_bus.wdata[7:0];
    // Prescaler advances on sys clock or on a sub-clock edge
    sub_edge = sub_s2_r & ~sub_s3_r;
    adv = csr_r[`WIT_CSR_PSS] ? sub_edge : 1'b1;
    mask = 8'((`WIT_PRE_TWO << csr_r[`WIT_CSR_CKS_HI:0]) - `WIT_PRE_ONE);
    tick = csr_r[`WIT_CSR_TME] & adv & ((pre_r & mask) == mask);
    if (adv) begin
      pre_nxt = pre_r + 8'h01;
    end
    if (tick) begin
      cnt_nxt = cnt_r + 8'h01;
    end
    ovf = tick & (cnt_r == `WIT_CNT_TOP);
    wd_ovf = ovf & csr_r[`WIT_CSR_MODE];
    it_ovf = ovf & ~csr_r[`WIT_CSR_MODE];
    if (lock_r != `WIT_CNT_ZERO) begin
      lock_nxt = lock_r - 8'h01;
    end
    // Byte writes and writes during lockout are dropped
    wr_ok = i_bus.wr & i_bus.word & (lock_r == `WIT_CNT_ZERO);
    wr_csr = wr_ok & (i_bus.addr == `WIT_ADDR_CSR);
    wr_rst = wr_ok & (i_bus.addr == `WIT_ADDR_RST_WR);
    if (wr_csr && hi == `WIT_KEY_CNT) begin
      cnt_nxt = lo;
    end
    if (wr_csr && hi == `WIT_KEY_CSR) begin
      csr_nxt[`WIT_CSR_MODE:0] = lo[`WIT_CSR_MODE:0];
      if (ovf_arm_r && !lo[`WIT_CSR_OVF]) begin
        csr_nxt[`WIT_CSR_OVF] = 1'b0;
        ovf_arm_nxt = 1'b0;
      end
    end
    if (wr_rst && hi == `WIT_KEY_WCLR) begin
      if (watchdog_overflow_flag_arm_r && !lo[`WIT_RST_WATCHDOG_OVERFLOW_FLAG]) begin
        watchdog_overflow_flag_nxt = 1'b0;
        watchdog_overflow_flag_arm_nxt = 1'b0;
      end
    end
    if (wr_rst && hi == `WIT_KEY_RESET_ENABLE_BIT) begin
      reset_enable_bit_nxt = lo[`WIT_RST_RESET_ENABLE_BIT];
      rsv_nxt = lo[`WIT_RST_RSV];
    end
    // Byte reads; a read of a set flag arms its clear, except a watchdog flag read during lockout
    if (i_bus.rd) begin
      case (i_bus.addr)
        `WIT_ADDR_CSR: begin
          rdata_nxt = csr_r;
          if (csr_r[`WIT_CSR_OVF]) begin
            ovf_arm_nxt = 1'b1;
          end
        end
        `WIT_ADDR_CNT_RD: begin
          rdata_nxt = cnt_r;
        end
        `WIT_ADDR_RST_RD: begin
          rdata_nxt = {watchdog_overflow_flag_r, reset_enable_bit_r, rsv_r, `WIT_RST_ONES};
          // Watchdog flag reads during lockout are not acknowledged
          if (watchdog_overflow_flag_r && lock_r == `WIT_CNT_ZERO) begin
            watchdog_overflow_flag_arm_nxt = 1'b1;
          end
        end
        default: begin
          rdata_nxt = `WIT_RD_NONE;
        end
      endcase
    end
    // Overflow wins over any clear in the same cycle
    if (it_ovf) begin
      csr_nxt[`WIT_CSR_OVF] = 1'b1;
      ovf_arm_nxt = 1'b0;
      lock_nxt = `WIT_LOCK_CYC;
    end
    if (wd_ovf) begin
      watchdog_overflow_flag_nxt = 1'b1;
      watchdog_overflow_flag_arm_nxt = 1'b0;
      cnt_nxt = `WIT_CNT_ZERO;
      csr_nxt = `WIT_CSR_INIT;
      ovf_arm_nxt = 1'b0;
      lock_nxt = `WIT_LOCK_CYC;
      if (reset_enable_bit_r) begin
        pst_nxt = WIT_RST;
        pulse_nxt = `WIT_RST0_CYC;
      end else if (csr_r[`WIT_CSR_RTS]) begin
        pst_nxt = WIT_RST;
        pulse_nxt = `WIT_RST1_CYC;
      end else begin
        pst_nxt = WIT_NMI;
        pulse_nxt = `WIT_NMI_CYC;
      end
    end else begin
      case (pst_r)
        WIT_IDLE: begin
          pulse_nxt = 10'h000;
        end
        WIT_RST, WIT_NMI: begin
          pulse_nxt = pulse_r - 10'h001;
          if (pulse_r == 10'h001) begin
            pst_nxt = WIT_IDLE;
          end
        end
        default: begin
          pst_nxt = WIT_IDLE;
          pulse_nxt = 10'h000;
        end
      endcase
    end
    // Chip reset is an output only; it does not reach the reset of the timer's own flops
    rst_o_nxt = (pst_nxt == WIT_RST) & (pulse_nxt != 10'h000);
    nmi_o_nxt = (pst_nxt == WIT_NMI) & (pulse_nxt != 10'h000);
    // Request follows the flag level until software clears it
    irq_nxt = csr_nxt[`WIT_CSR_OVF];
  end

  // Only the pin reset reaches these flops; our own pulse does not
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= `WIT_CNT_ZERO;
      csr_r <= `WIT_CSR_INIT;
      watchdog_overflow_flag_r <= 1'b0;
      reset_enable_bit_r <= 1'b0;
      rsv_r <= 1'b0;
      pre_r <= 8'h00;
      sub_s1_r <= 1'b0;
      sub_s2_r <= 1'b0;
      sub_s3_r <= 1'b0;
      ovf_arm_r <= 1'b0;
      watchdog_overflow_flag_arm_r <= 1'b0;
      lock_r <= `WIT_CNT_ZERO;
      pulse_r <= 10'h000;
      pst_r <= WIT_IDLE;
      rdata_r <= `WIT_RD_NONE;
      rst_o_r <= 1'b0;
      nmi_o_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      csr_r <= csr_nxt;
      watchdog_overflow_flag_r <= watchdog_overflow_flag_nxt;
      reset_enable_bit_r <= reset_enable_bit_nxt;
      rsv_r <= rsv_nxt;
      pre_r <= pre_nxt;
      sub_s1_r <= i_sub_clk;
      sub_s2_r <= sub_s1_r;
      sub_s3_r <= sub_s2_r;
      ovf_arm_r <= ovf_arm_nxt;
      watchdog_overflow_flag_arm_r <= watchdog_overflow_flag_arm_nxt;
      lock_r <= lock_nxt;
      pulse_r <= pulse_nxt;
      pst_r <= pst_nxt;
      rdata_r <= rdata_nxt;
      rst_o_r <= rst_o_nxt;
      nmi_o_r <= nmi_o_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign o_bus_rdata = rdata_r;
  assign o_chip_rst = rst_o_r;
  assign o_wdog_nmi = nmi_o_r;
  assign o_interval_irq = irq_r;

  // Length of the current reset pulse, read only by checks
  logic [9:0] hi_len_r;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hi_len_r <= 10'h000;
    end else begin
      hi_len_r <= rst_o_r ? hi_len_r + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_wd_ovf;
    wd_ovf;
  endsequence
  sequence s_rd_rst;
    i_bus.rd && (i_bus.addr == `WIT_ADDR_RST_RD);
  endsequence

  AST_WATCHDOG_OVERFLOW_FLAG_SET: assert property (s_wd_ovf |=> watchdog_overflow_flag_r)
    else $error("watchdog flag not set on overflow");
  AST_WATCHDOG_OVERFLOW_FLAG_CAUSE: assert property ($rose(watchdog_overflow_flag_r) |-> $past(wd_ovf))
    else $error("watchdog flag set without watchdog overflow");
  AST_WATCHDOG_OVERFLOW_FLAG_HOLD: assert property (watchdog_overflow_flag_r && !watchdog_overflow_flag_arm_r |=> watchdog_overflow_flag_r)
    else $error("watchdog flag cleared without prior read");
  AST_RST_LEN: assert property ($fell(rst_o_r) |->
    (hi_len_r == `WIT_RST0_CYC || hi_len_r == `WIT_RST1_CYC))
    else $error("chip reset pulse has wrong length");
  AST_RST_START: assert property (s_wd_ovf ##0 reset_enable_bit_r |=> rst_o_r [*8])
    else $error("chip reset not driven after overflow");
  AST_NMI_RUN: assert property (s_wd_ovf ##0
    (!reset_enable_bit_r && !csr_r[`WIT_CSR_RTS])
    |=> (nmi_o_r && !rst_o_r) [*8])
    else $error("nmi request not driven after overflow");
  AST_OVF_IRQ: assert property (it_ovf |=> csr_r[`WIT_CSR_OVF] && irq_r)
    else $error("interval flag and request not raised together");
  AST_WRITE_WINS: assert property (tick && wr_csr && hi == `WIT_KEY_CNT
    && !ovf |=> cnt_r == $past(lo))
    else $error("count pulse overrode a counter write");
  AST_LOCKOUT: assert property (lock_r != `WIT_CNT_ZERO && !ovf
    |=> csr_r[`WIT_CSR_MODE:0] == $past(csr_r[`WIT_CSR_MODE:0]))
    else $error("control written during lockout");
  AST_RSV_ONES: assert property (s_rd_rst |=> rdata_r[4:0] == `WIT_RST_ONES)
    else $error("reserved bits did not read as ones");
  AST_BYTE_WR: assert property (i_bus.wr && !i_bus.word && !tick
    && !ovf |=> cnt_r == $past(cnt_r))
    else $error("byte write changed the counter");

endmodule

// ---- dv/wit_cpu_model.sv ----
// Processor-side register bus model for the timer
`timescale 1ns/100ps
module wit_cpu_model
  import wit_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Bus towards the timer
  output wit_bus_req_s o_bus,
  input wire logic [7:0] i_rdata
);
  initial o_bus = '0;
  // Keyed write; word form only reaches registers
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic w = 1'b1);
    @(posedge i_sys_clk) #2;
    o_bus = '{a, d, 1'b1, w, 1'b0};
    @(posedge i_sys_clk) #2;
    // Released lines flip so stale values never look valid
    o_bus = '{~a, ~d, 1'b0, w, 1'b0};
  endtask
  // Byte read, data taken one edge later
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    @(posedge i_sys_clk) #2;
    o_bus = '{a, ~o_bus.wdata, 1'b0, 1'b0, 1'b1};
    @(posedge i_sys_clk) #2;
    q = i_rdata;
    o_bus = '{~a, o_bus.wdata, 1'b0, 1'b0, 1'b0};
  endtask
endmodule

// ---- dv/test_watchdog_interval_timer.sv ----
// Self-checking bench for the watchdog and interval timer
`timescale 1ns/100ps
`include "wit_consts.svh"
module test_watchdog_interval_timer
  import wit_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_sub_clk = 1'b0;
  wit_bus_req_s bus;
  logic [7:0] rdata;
  logic [7:0] q;
  logic chip_rst, nmi, irq;
  int fails = 0;
  int cmp_count = 0;
  int seed = 32'h6647_9ae2;
  int n, len;
  // Expected reset control/status contents
  logic [7:0] m_rst = 8'h1F;

  always #10 i_sys_clk = ~i_sys_clk;
  always #140 i_sub_clk = ~i_sub_clk;

  wit_timer uut(.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_bus(bus),
    .o_bus_rdata(rdata), .i_sub_clk(i_sub_clk), .o_chip_rst(chip_rst),
    .o_wdog_nmi(nmi), .o_interval_irq(irq));
  wit_cpu_model cpu(.i_sys_clk(i_sys_clk), .o_bus(bus), .i_rdata(rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    cpu.rd(a, q);
    chk({8'h00, q}, {8'h00, exp});
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? chip_rst : (s == 1 ? nmi : irq);
  endfunction
  // Bounded wait for a request line to rise
  task automatic wait_hi(input int s);
    for (int k = 0; k < 4000 && !sig(s); k++) @(posedge i_sys_clk) #1;
  endtask
  // Length of a request pulse in clock cycles
  task automatic pulse(input int s, output int l);
    l = 0;
    wait_hi(s);
    while (sig(s) === 1'b1 && l < 2000) begin
      @(posedge i_sys_clk) #1;
      l++;
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge i_sys_clk);
    #2 i_arst_n = 1'b1;
    rchk(`WIT_ADDR_RST_RD, m_rst);
    rchk(`WIT_ADDR_CSR, 8'h00);
    cpu.wr(`WIT_ADDR_CSR, 16'hA520, 1'b0);
    cpu.wr(`WIT_ADDR_CSR, 16'h3C20);
    cpu.wr(`WIT_ADDR_RST_WR, 16'h5A40, 1'b0);
    rchk(`WIT_ADDR_CSR, 8'h00);
    rchk(`WIT_ADDR_RST_RD, m_rst);
    repeat (6) begin
      n = $random(seed);
      cpu.wr(`WIT_ADDR_CSR, {`WIT_KEY_CNT, n[7:0]});
      rchk(`WIT_ADDR_CNT_RD, n[7:0]);
    end
    cpu.wr(`WIT_ADDR_RST_WR, {`WIT_KEY_RESET_ENABLE_BIT, 8'h40});
    rchk(`WIT_ADDR_RST_RD, 8'h5F);
    // Interval mode: flag and request rise together
    cpu.wr(`WIT_ADDR_CSR, {`WIT_KEY_CNT, 8'hF0});
    cpu.wr(`WIT_ADDR_CSR, {`WIT_KEY_CSR, 8'h20});
    wait_hi(2);
    rchk(`WIT_ADDR_CSR, 8'hA0);
    rchk(`WIT_ADDR_RST_RD, 8'h5F);
    chk({chip_rst, nmi}, 16'h0000);
    repeat (140) @(posedge i_sys_clk);
    rchk(`WIT_ADDR_CSR, 8'hA0);
    cpu.wr(`WIT_ADDR_CSR, {`WIT_KEY_CSR, 8'h00});
    chk(irq, 1'b0);
    // Watchdog with chip reset; writes locked after overflow
    cpu.wr(`WIT_ADDR_RST_WR, {`WIT_KEY_RESET_ENABLE_BIT, 8'h40});
    cpu.wr(`WIT_ADDR_CSR, {`WIT_KEY_CNT, 8'hF0});
    cpu.wr(`WIT_ADDR_CSR, {`WIT_KEY_CSR, 8'h60});
    fork
      pulse(0, len);
      begin
        wait_hi(0);
        cpu.wr(`WIT_ADDR_CSR, {`WIT_KEY_CSR, 8'h20});
        rchk(`WIT_ADDR_CSR, 8'h00);
      end
    join
    chk(16'(len), 16'd518);
    m_rst = 8'hDF;
    rchk(`WIT_ADDR_RST_RD, m_rst);
    cpu.wr(`WIT_ADDR_RST_WR, {`WIT_KEY_WCLR, 8'h80});
    rchk(`WIT_ADDR_RST_RD, m_rst);
    cpu.wr(`WIT_ADDR_RST_WR, {`WIT_KEY_WCLR, 8'h00});
    m_rst = 8'h5F;
    rchk(`WIT_ADDR_RST_RD, m_rst);
    // Reset-enable clear: reset-type reset, then sub-clock NMI
    cpu.wr(`WIT_ADDR_RST_WR, {`WIT_KEY_RESET_ENABLE_BIT, 8'h00});
    // Each pulse ends before the next run starts, so the two requests never overlap
    for (n = 0; n < 2; n++) begin
      cpu.wr(`WIT_ADDR_CSR, {`WIT_KEY_CNT, 8'hF0});
      cpu.wr(`WIT_ADDR_CSR, {`WIT_KEY_CSR, n ? 8'h70 : 8'h68});
      pulse(n, len);
      chk(16'(len + (n && len == 515)), 16'd516);
      rchk(`WIT_ADDR_RST_RD, 8'h9F);
    end
    // Pin reset clears the flag and restores the init value
    @(posedge i_sys_clk) #2 i_arst_n = 1'b0;
    @(posedge i_sys_clk) #2 i_arst_n = 1'b1;
    rchk(`WIT_ADDR_RST_RD, 8'h1F);
    wrap_up();
  end

  // Run needs about 2400 cycles; twenty times that is a hang
  initial begin
    #1_000_000;
    fails++;
    wrap_up();
  end
endmodule
